// *** disp_cfg_pkg.sv ***
// Constants, field layout and carrier types for the display, clock and mux config bank.
// Assumes a 32-bit classic Wishbone slave with 8-bit registers in byte lane 0.
package disp_cfg_pkg;
  // Register indices; byte address is four times the index
  localparam int ADR_W = 16;
  localparam logic [13:0] IDX_BOOT = 14'h00b2;
  localparam logic [13:0] IDX_MUX_STATE = 14'h2002;
  localparam logic [13:0] IDX_CLK_DIV = 14'h2004;
  localparam logic [13:0] IDX_MUX_SEL = 14'h2005;
  localparam logic [13:0] IDX_OPT_TX = 14'h2008;
  localparam logic [13:0] IDX_DISP_CFG = 14'h2020;
  localparam logic [13:0] IDX_SEG_FIRST = 14'h2030;
  localparam logic [13:0] IDX_SEG_LAST = 14'h2059;
  // Field positions
  localparam int POS_PREBOOT = 7;
  localparam int POS_MUX_CNT = 6;
  localparam int POS_DIV = 0;
  localparam int POS_ALT = 2;
  localparam int POS_SYNC_EN = 0;
  localparam int POS_OPT_DIS = 5;
  localparam int POS_PIN_CNT = 0;
  // Reset values
  localparam logic [4:0] RST_PIN_CNT = 5'h00;
  localparam logic [2:0] RST_DIV = 3'h0;
  localparam logic [1:0] RST_MUX_CNT = 2'h0;
  localparam logic RST_ALT = 1'b0;
  localparam logic RST_SYNC_EN = 1'b0;
  localparam logic RST_OPT_DIS = 1'b0;
  localparam logic [3:0] RST_SEG = 4'h0;
  // Mux state counts per code
  localparam logic [2:0] MUX_STATES_0 = 3'h6;
  localparam logic [2:0] MUX_STATES_1 = 3'h4;
  localparam logic [2:0] MUX_STATES_2 = 3'h3;
  localparam logic [2:0] MUX_STATES_3 = 3'h2;
  // Wishbone request bundle
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
  } wb_req_t;
  // Input multiplexer settings
  typedef struct packed {
    logic [2:0] states;
    logic alt;
    logic sync_en;
  } mux_cfg_t;
endpackage

// *** disp_cfg_regs.sv ***
// Config bank: display pin split, segment plane words, processor clock divide, input mux.
// Assumes a classic Wishbone master on clk_i; preboot and output_a are synchronous inputs.
// How it works
// - Pins go to display from top segment pin downward, count 0 to 18.
// - Four-bit word per segment 0..41; bit 0 drives common plane zero.
// - Processor clock is engine clock over two to the code; change anytime.
// - Mux state count code: 00 six, 01 four, 10 three, 11 two.
// - Sync enable turns segment pin seven into the output_a output.
// - Read-only preboot flag at bit 7 of boot flash control.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
module disp_cfg_regs #(
  parameter int PINS = 18,
  parameter int SEGS = 42
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire disp_cfg_pkg::wb_req_t wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Status inputs
  input wire logic preboot_i,
  input wire logic output_a_i,
  input wire logic pin_seven_lcd_i,
  // Configuration outputs
  output logic [PINS-1:0] seg_display_o,
  output logic [SEGS*4-1:0] seg_planes_o,
  output logic engine_clk_en_o,
  output disp_cfg_pkg::mux_cfg_t mux_cfg_o,
  output logic pin_seven_o,
  output logic opt_tx_disable_o
);
  import disp_cfg_pkg::*;

  // Parameter check
  if (PINS < 1 || PINS > 31 || SEGS != int'(IDX_SEG_LAST - IDX_SEG_FIRST) + 1) begin : g_chk
    $error("disp_cfg_regs: unsupported PINS or SEGS");
  end

  // Segment window decode
  function automatic logic is_seg(input logic [13:0] idx);
    is_seg = (idx >= IDX_SEG_FIRST) && (idx <= IDX_SEG_LAST);
  endfunction

  // Mux state count decode
  function automatic logic [2:0] states_of(input logic [1:0] code);
    case (code)
      2'h0: states_of = MUX_STATES_0;
      2'h1: states_of = MUX_STATES_1;
      2'h2: states_of = MUX_STATES_2;
      default: states_of = MUX_STATES_3;
    endcase
  endfunction

  logic [13:0] idx;
  logic req;
  logic wr;
  logic [5:0] seg_sel;
  assign idx = wb_i.adr[15:2];
  assign req = wb_i.cyc & wb_i.stb;
  // Write lands on the acknowledging edge only
  assign wr = req & wb_i.we & wb_ack_o & wb_i.sel[0];
  assign seg_sel = 6'(idx - IDX_SEG_FIRST);

  // ---------------- Bus handshake and read data
  logic ack_nxt;
  logic [31:0] dat_nxt;
  logic [7:0] rd;
  logic [3:0] seg_r [SEGS];
  logic [4:0] pin_cnt_r;
  logic [2:0] div_r;
  logic [1:0] mux_cnt_r;
  logic alt_r, sync_en_r, opt_dis_r, preboot_r;

  // Ack one cycle after request, dropped the cycle after
  always_comb begin
    rd = 8'h00;
    ack_nxt = req & ~wb_ack_o;
    if (idx == IDX_BOOT) begin
      rd[POS_PREBOOT] = preboot_r;
    end else if (idx == IDX_MUX_STATE) begin
      rd[POS_MUX_CNT +: 2] = mux_cnt_r;
    end else if (idx == IDX_CLK_DIV) begin
      rd[POS_DIV +: 3] = div_r;
    end else if (idx == IDX_MUX_SEL) begin
      rd[POS_ALT] = alt_r;
      rd[POS_SYNC_EN] = sync_en_r;
    end else if (idx == IDX_OPT_TX) begin
      rd[POS_OPT_DIS] = opt_dis_r;
    end else if (idx == IDX_DISP_CFG) begin
      rd[POS_PIN_CNT +: 5] = pin_cnt_r;
    end else if (is_seg(idx)) begin
      rd[3:0] = seg_r[seg_sel];
    end
    dat_nxt = (ack_nxt && !wb_i.we) ? {24'h00_0000, rd} : 32'h0000_0000;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= ack_nxt;
      wb_dat_o <= dat_nxt;
    end
  end

  // ---------------- Control registers
  logic [4:0] pin_cnt_nxt;
  logic [2:0] div_nxt;
  logic [1:0] mux_cnt_nxt;
  logic alt_nxt, sync_en_nxt, opt_dis_nxt;
  logic [3:0] seg_nxt [SEGS];

  // Register writes with pin count clamp
  always_comb begin
    pin_cnt_nxt = pin_cnt_r;
    div_nxt = div_r;
    mux_cnt_nxt = mux_cnt_r;
    alt_nxt = alt_r;
    sync_en_nxt = sync_en_r;
    opt_dis_nxt = opt_dis_r;
    seg_nxt = seg_r;
    if (wr) begin
      if (idx == IDX_MUX_STATE) begin
        mux_cnt_nxt = wb_i.dat[POS_MUX_CNT +: 2];
      end else if (idx == IDX_CLK_DIV) begin
        div_nxt = wb_i.dat[POS_DIV +: 3];
      end else if (idx == IDX_MUX_SEL) begin
        alt_nxt = wb_i.dat[POS_ALT];
        sync_en_nxt = wb_i.dat[POS_SYNC_EN];
      end else if (idx == IDX_OPT_TX) begin
        opt_dis_nxt = wb_i.dat[POS_OPT_DIS];
      end else if (idx == IDX_DISP_CFG) begin
        if (wb_i.dat[POS_PIN_CNT +: 5] > 5'(PINS)) begin
          pin_cnt_nxt = 5'(PINS);
        end else begin
          pin_cnt_nxt = wb_i.dat[POS_PIN_CNT +: 5];
        end
      end else if (is_seg(idx)) begin
        seg_nxt[seg_sel] = wb_i.dat[3:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_cnt_r <= RST_PIN_CNT;
      div_r <= RST_DIV;
      mux_cnt_r <= RST_MUX_CNT;
      alt_r <= RST_ALT;
      sync_en_r <= RST_SYNC_EN;
      opt_dis_r <= RST_OPT_DIS;
      for (int i = 0; i < SEGS; i++) begin
        seg_r[i] <= RST_SEG;
      end
    end else begin
      pin_cnt_r <= pin_cnt_nxt;
      div_r <= div_nxt;
      mux_cnt_r <= mux_cnt_nxt;
      alt_r <= alt_nxt;
      sync_en_r <= sync_en_nxt;
      opt_dis_r <= opt_dis_nxt;
      seg_r <= seg_nxt;
    end
  end

  // Segment words flattened, bit 0 of each is common plane zero
  for (genvar s = 0; s < SEGS; s++) begin : g_seg
    assign seg_planes_o[s*4 +: 4] = seg_r[s];
  end

  // ---------------- Derived outputs
  logic [PINS-1:0] disp_nxt;
  logic [6:0] div_cnt_r, div_cnt_nxt, div_mask;
  logic clk_en_nxt, pin_seven_nxt;
  mux_cfg_t mux_nxt;

  // Bit i is pin 42-PINS+i; top pins claimed first
  for (genvar p = 0; p < PINS; p++) begin : g_pin
    assign disp_nxt[p] = 5'(p) >= 5'(PINS) - pin_cnt_r;
  end

  // Free-running divider; a new code takes effect without stalling
  always_comb begin
    div_mask = ~(7'h7f << div_r);
    div_cnt_nxt = div_cnt_r + 7'h01;
    clk_en_nxt = (div_cnt_r & div_mask) == div_mask;
    mux_nxt.states = states_of(mux_cnt_r);
    mux_nxt.alt = alt_r;
    mux_nxt.sync_en = sync_en_r;
    pin_seven_nxt = sync_en_r ? output_a_i : pin_seven_lcd_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seg_display_o <= '0;
      div_cnt_r <= 7'h00;
      engine_clk_en_o <= 1'b0;
      mux_cfg_o <= '0;
      pin_seven_o <= 1'b0;
      opt_tx_disable_o <= 1'b0;
      preboot_r <= 1'b0;
    end else begin
      seg_display_o <= disp_nxt;
      div_cnt_r <= div_cnt_nxt;
      engine_clk_en_o <= clk_en_nxt;
      mux_cfg_o <= mux_nxt;
      pin_seven_o <= pin_seven_nxt;
      opt_tx_disable_o <= opt_dis_r;
      preboot_r <= preboot_i;
    end
  end

  // ---------------- Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_answer_once: assert property (req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse after request");
  a_pin_count_clamp: assert property (pin_cnt_r <= 5'(PINS))
    else $error("pin count above maximum");
  a_top_pin_first: assert property (pin_cnt_r != 5'h00 |=> seg_display_o[PINS-1])
    else $error("top segment pin not on display");
  a_all_gpio_zero: assert property (pin_cnt_r == 5'h00 |=> seg_display_o == '0)
    else $error("display pins claimed with zero count");
  a_seg_word_write: assert property (wr && is_seg(idx) |=>
      seg_r[$past(seg_sel)] == $past(wb_i.dat[3:0]))
    else $error("segment word not stored");
  // Sampled reset in the antecedent keeps the release edge from firing
  a_div_no_split: assert property (!rst_i && div_r == 3'h0 && $stable(div_r)
      |=> engine_clk_en_o)
    else $error("undivided clock enable missing");
  a_div_two_gap: assert property (engine_clk_en_o && div_r == 3'h1 && $past(div_r) == 3'h1
      |=> !engine_clk_en_o)
    else $error("divide by two enable too frequent");
  a_mux_state_map: assert property (!rst_i |=> mux_cfg_o.states == states_of($past(mux_cnt_r)))
    else $error("mux state count mismatch");
  a_sync_pin_route: assert property (sync_en_r |=> pin_seven_o == $past(output_a_i))
    else $error("segment seven not carrying sync");
  a_preboot_read: assert property (req && !wb_i.we && !wb_ack_o && idx == IDX_BOOT
      |=> wb_dat_o[POS_PREBOOT] == $past(preboot_r))
    else $error("preboot flag misread");
endmodule

// *** disp_cfg_regs_tb.sv ***
// Self-checking bench for the display, clock and mux config bank.
// Assumes the bank answers classic Wishbone one cycle after taking a request.
`timescale 1ns/1ps
module disp_cfg_regs_tb;
  import disp_cfg_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wb_req_t wb_i = '0;
  logic preboot_i = 1'b0;
  logic output_a_i = 1'b0;
  logic pin_seven_lcd_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [17:0] seg_display_o;
  logic [167:0] seg_planes_o;
  logic engine_clk_en_o;
  mux_cfg_t mux_cfg_o;
  logic pin_seven_o;
  logic opt_tx_disable_o;
  int n_fail = 0;
  int total_checks = 0;
  logic [7:0] rd;

  disp_cfg_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .preboot_i(preboot_i), .output_a_i(output_a_i),
    .pin_seven_lcd_i(pin_seven_lcd_i), .seg_display_o(seg_display_o),
    .seg_planes_o(seg_planes_o),
    .engine_clk_en_o(engine_clk_en_o), .mux_cfg_o(mux_cfg_o), .pin_seven_o(pin_seven_o),
    .opt_tx_disable_o(opt_tx_disable_o));

  // Free-running clock, 4 ns period
  always #2 clk_i = ~clk_i;

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle; waits for ack under a bound
  task automatic wb(input logic we, input logic [13:0] idx, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, dat: {24'h0, d}, sel: 4'hf};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o[7:0];
    wb_i <= '0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_i);
  endtask

  // Pin split from the top downward, and clamp of large counts
  task automatic t_pins();
    wb(1'b1, IDX_DISP_CFG, 8'h02, rd);
    settle();
    chk(seg_display_o, 32'h3_0000);
    wb(1'b1, IDX_DISP_CFG, 8'h19, rd);
    wb(1'b0, IDX_DISP_CFG, 8'h00, rd);
    chk(rd, 32'h12);
    settle();
    chk(seg_display_o, 32'h3_ffff);
  endtask

  // First and last segment words land in their own nibbles
  task automatic t_seg();
    wb(1'b1, IDX_SEG_FIRST, 8'h05, rd);
    wb(1'b1, IDX_SEG_LAST, 8'h0a, rd);
    wb(1'b0, IDX_SEG_LAST, 8'h00, rd);
    chk(rd, 32'ha);
    settle();
    chk(seg_planes_o[3:0], 32'h5);
    chk(seg_planes_o[167:164], 32'ha);
  endtask

  // Enable pulse rate follows the divide code, retuned on the fly
  task automatic t_div();
    int cnt;
    logic [2:0] codes [4];
    codes = '{3'h0, 3'h1, 3'h3, 3'h7};
    foreach (codes[k]) begin
      wb(1'b1, IDX_CLK_DIV, {5'h0, codes[k]}, rd);
      settle();
      cnt = 0;
      repeat (128) begin
        @(posedge clk_i);
        if (engine_clk_en_o === 1'b1) cnt++;
      end
      chk(cnt, 32'd128 >> codes[k]);
    end
  endtask

  // Every state-count code, then alternate input select
  task automatic t_mux();
    logic [2:0] exp [4];
    exp = '{MUX_STATES_0, MUX_STATES_1, MUX_STATES_2, MUX_STATES_3};
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, IDX_MUX_STATE, {c[1:0], 6'h0}, rd);
      settle();
      chk(mux_cfg_o.states, exp[c]);
    end
    wb(1'b1, IDX_MUX_SEL, 8'h04, rd);
    settle();
    chk(mux_cfg_o.alt, 32'h1);
  endtask

  // Segment pin seven swaps to the sync signal only while enabled
  task automatic t_sync();
    wb(1'b1, IDX_MUX_SEL, 8'h01, rd);
    output_a_i <= 1'b1;
    pin_seven_lcd_i <= 1'b0;
    settle();
    chk(pin_seven_o, 32'h1);
    chk(mux_cfg_o.sync_en, 32'h1);
    output_a_i <= 1'b0;
    pin_seven_lcd_i <= 1'b1;
    settle();
    chk(pin_seven_o, 32'h0);
    wb(1'b1, IDX_MUX_SEL, 8'h00, rd);
    settle();
    chk(pin_seven_o, 32'h1);
  endtask

  // Read-only preboot flag and an unmapped place
  task automatic t_boot();
    wb(1'b0, IDX_BOOT, 8'h00, rd);
    chk(rd, 32'h0);
    preboot_i <= 1'b1;
    settle();
    wb(1'b1, IDX_BOOT, 8'h7f, rd);
    wb(1'b0, IDX_BOOT, 8'h00, rd);
    chk(rd, 32'h80);
    wb(1'b1, 14'h2100, 8'hff, rd);
    wb(1'b0, 14'h2100, 8'h00, rd);
    chk(rd, 32'h0);
  endtask

  // Optical disable bit, then a mid-run reset back to defaults
  task automatic t_reset();
    wb(1'b1, IDX_OPT_TX, 8'h20, rd);
    wb(1'b0, IDX_OPT_TX, 8'h00, rd);
    chk(rd, 32'h20);
    settle();
    chk(opt_tx_disable_o, 32'h1);
    rst_i <= 1'b1;
    settle();
    rst_i <= 1'b0;
    wb(1'b0, IDX_DISP_CFG, 8'h00, rd);
    chk(rd, 32'h0);
    wb(1'b0, IDX_CLK_DIV, 8'h00, rd);
    chk(rd, 32'h0);
    settle();
    chk(seg_display_o, 32'h0);
    chk(mux_cfg_o.states, MUX_STATES_0);
    chk(opt_tx_disable_o, 32'h0);
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_pins();
    t_seg();
    t_div();
    t_mux();
    t_sync();
    t_boot();
    t_reset();
    give_verdict();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    give_verdict();
  end
endmodule
